// ### flash_status_cfg.svh
// Purpose: constants of the flash status register bank
// Assumes: one 10 MHz clock (100 ns period)
// Notes:   definitions only
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define FS_CMD_WRITE_UNLOCK  8'h06
`define FS_CMD_WRITE_LOCK    8'h04
`define FS_CMD_READ_SR1      8'h05
`define FS_CMD_READ_SR2      8'h35
`define FS_CMD_READ_SR3      8'h15
`define FS_CMD_WRITE_SR1     8'h01
`define FS_CMD_WRITE_SR2     8'h31
`define FS_CMD_WRITE_SR3     8'h11
`define FS_CMD_PROG_3B       8'h02
`define FS_CMD_PROG_4B       8'h12
`define FS_CMD_QPROG_3B      8'h32
`define FS_CMD_QPROG_4B      8'h34
`define FS_CMD_WIPE_SMALL_3B 8'h20
`define FS_CMD_WIPE_SMALL_4B 8'h21
`define FS_CMD_WIPE_32K_3B   8'h52
`define FS_CMD_WIPE_32K_4B   8'h5C
`define FS_CMD_WIPE_64K_3B   8'hD8
`define FS_CMD_WIPE_64K_4B   8'hDC
`define FS_CMD_WIPE_ALL_A    8'h60
`define FS_CMD_WIPE_ALL_B    8'hC7
`define FS_CMD_READ_3B       8'h03
`define FS_CMD_READ_4B       8'h13
`define FS_CMD_FREAD_3B      8'h0B
`define FS_CMD_FREAD_4B      8'h0C
`define FS_CMD_DREAD_3B      8'h3B
`define FS_CMD_DREAD_4B      8'h3C
`define FS_CMD_DIOREAD_3B    8'hBB
`define FS_CMD_DIOREAD_4B    8'hBC
`define FS_CMD_QREAD_3B      8'h6B
`define FS_CMD_QREAD_4B      8'h6C
`define FS_CMD_QIOREAD_3B    8'hEB
`define FS_CMD_QIOREAD_4B    8'hEC
`define FS_CMD_ENTER_4B      8'hB7
`define FS_CMD_EXIT_4B       8'hE9
`define FS_CMD_SUSPEND       8'h75
`define FS_CMD_RESUME        8'h7A
`define FS_CMD_RESET_ARM     8'h66
`define FS_CMD_RESET_FIRE    8'h99

// ----------------------------------------------------------------------
// reset values (factory state of the three status bytes)
// ----------------------------------------------------------------------
`define FS_SR1_RST 8'h00
`define FS_SR2_RST 8'h00
`define FS_SR3_RST 8'h20

// ----------------------------------------------------------------------
// dummy cycle counts
// ----------------------------------------------------------------------
`define FS_DUMMY_DUAL_SHORT 4'h4
`define FS_DUMMY_DUAL_LONG  4'h8
`define FS_DUMMY_QUAD_SHORT 4'h6
`define FS_DUMMY_QUAD_LONG  4'hA

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FS_CLK_NS        100
`define FS_RST_LOW_NS    1000
`define FS_RST_LOW_CYC   ((`FS_RST_LOW_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)
`define FS_SRW_BUSY_CYC  16

`endif

// ### flash_status_pkg.sv
// Purpose: types shared by the flash status register bank
// Assumes: constants live in flash_status_cfg.svh
// Notes:   struct fields are listed most significant bit first
package flash_status_pkg;

  // --------------------------------------------------------------------
  // status bytes
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       lock_mode_bit0;
    logic [4:0] protect_range_bits;  // bit4 down to bit0
    logic       write_enable_latch;
    logic       write_busy_flag;
  } sr1_t;

  typedef struct packed {
    logic erase_paused_flag;
    logic lock_mode_bit1;
    logic security_lock_3;
    logic security_lock_2;
    logic security_lock_1;
    logic program_paused_flag;
    logic quad_io_enable;
    logic current_addr_width_flag;
  } sr2_t;

  typedef struct packed {
    logic pause_or_reset_select;
    logic output_strength_hi;
    logic output_strength_lo;
    logic powerup_addr_width;
    logic erase_fail_flag;
    logic program_fail_flag;
    logic latency_sel_hi;
    logic latency_sel_lo;
  } sr3_t;

  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic busy;
    logic fail;
    logic protHit;
  } arr_evt_t;

  typedef enum logic [1:0] {
    DRIVE_FULL,
    DRIVE_3Q,
    DRIVE_HALF,
    DRIVE_1Q
  } drive_t;

  typedef enum logic {
    ST_IDLE,
    ST_SRW_BUSY
  } state_t;

endpackage : flash_status_pkg

// ### flash_pin_sync.sv
// Purpose: two-stage synchroniser for the pins of the flash bank
// Assumes: pins are asynchronous to ref_clk
// Notes:   stage one is read by stage two only
`timescale 1ns/100ps
module flash_pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] dout_d;

  always_comb begin
    meta_d = clkEn ? din : meta_q;
    dout_d = clkEn ? meta_q : dout;
  end

  // pins idle high, so reset to ones
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {WIDTH{1'b1}};
      dout   <= {WIDTH{1'b1}};
    end else begin
      meta_q <= meta_d;
      dout   <= dout_d;
    end
  end

endmodule : flash_pin_sync

// ### flash_status_register_bank.sv
// Purpose: three status bytes of a serial flash and their side effects
// Assumes: a serial front end on ref_clk delivers whole command bytes
// Notes:   non-volatile storage is not modelled; resetn is a power cycle
`timescale 1ns/100ps
`include "flash_status_cfg.svh"

// How it works
// - busy flag is high during program, erase or status write, else low.
// - with write latch clear, status writes, programs and erases are refused.
// - five protect range bits are published for the array to guard.
// - protect range bits change only when hardware protection is off.
// - lock mode 00 accepts status writes whenever the latch is set.
// - lock mode 01 blocks writes while protect pin low and quad enable clear, else allows.
// - lock mode 10 refuses writes until power cycle, which returns 00.
// - lock mode 11 refuses every status write until power cycle, which returns 00.
// - address width flag is read only: 0 three-byte, 1 four-byte.
// - quad enable turns protect and pause pins into data lines.
// - security locks default 0, set one by one, clear only on power cycle.
// - suspend sets erase or program paused flag; both read only.
// - resume, software reset and power cycle clear paused flags.
// - dummy cycles: dual 4 or 8, quad 6 or 10, by latency low bit.
// - program fail flag sets on failure or protected hit, clears on resume.
// - erase fail flag sets on failure or protected hit, clears on resume.
// - power-up address width bit picks start address mode.
// - power-up address width is read only at reset time.
// - drive strength: 00 full, 01 three quarters, 10 half, 11 quarter.
// - select bit 0 makes shared pin pause, 1 makes it reset.
// - quad enable disables both pause and reset on shared pin.
// - write latch sets on unlock, clears on reset and write operations.
// - status bytes read by 05/35/15, written by 01/31/11 plus one byte.
// - quad reads run only while quad enable is set.
module flash_status_register_bank #(
  parameter int SRW_BUSY_CYC = `FS_SRW_BUSY_CYC,
  parameter int RST_LOW_CYC  = `FS_RST_LOW_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  input  wire logic                      clkEn,
  input  flash_status_pkg::cmd_t         cmdIn,
  input  flash_status_pkg::arr_evt_t     arrEvt,
  input  wire logic                      write_protect_pin_n,
  input  wire logic                      holdResetPinN,
  output flash_status_pkg::sr1_t         sr1_q,
  output flash_status_pkg::sr2_t         sr2_q,
  output flash_status_pkg::sr3_t         sr3_q,
  output logic [7:0]                     readData_q,
  output logic                           readValid_q,
  output logic                           cmdReject_q,
  output logic                           opStart_q,
  output logic [7:0]                     opCode_q,
  output logic                           readGrant_q,
  output logic                           suspendReq_q,
  output logic                           resumeReq_q,
  output logic [3:0]                     dummyDual_q,
  output logic [3:0]                     dummyQuad_q,
  output flash_status_pkg::drive_t       driveStrength_q,
  output logic                           quadPins_q,
  output logic                           wpActive_q,
  output logic                           holdActive_q,
  output logic                           pinReset_q
);
  import flash_status_pkg::*;

  localparam int BCW = $clog2(SRW_BUSY_CYC + 1);
  localparam int RCW = $clog2(RST_LOW_CYC + 1);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [3:0] dummy_cycles(input logic lo,
                                              input logic quad);
    if (quad)
      dummy_cycles = lo ? `FS_DUMMY_QUAD_LONG : `FS_DUMMY_QUAD_SHORT;
    else
      dummy_cycles = lo ? `FS_DUMMY_DUAL_LONG : `FS_DUMMY_DUAL_SHORT;
  endfunction : dummy_cycles

  function automatic logic is_program(input logic [7:0] c);
    is_program = (c == `FS_CMD_PROG_3B)  || (c == `FS_CMD_PROG_4B) ||
                 (c == `FS_CMD_QPROG_3B) || (c == `FS_CMD_QPROG_4B);
  endfunction : is_program

  function automatic logic is_erase(input logic [7:0] c);
    is_erase = (c == `FS_CMD_WIPE_SMALL_3B) || (c == `FS_CMD_WIPE_SMALL_4B) ||
               (c == `FS_CMD_WIPE_32K_3B)   || (c == `FS_CMD_WIPE_32K_4B) ||
               (c == `FS_CMD_WIPE_64K_3B)   || (c == `FS_CMD_WIPE_64K_4B) ||
               (c == `FS_CMD_WIPE_ALL_A)    || (c == `FS_CMD_WIPE_ALL_B);
  endfunction : is_erase

  function automatic logic is_plain_read(input logic [7:0] c);
    is_plain_read = (c == `FS_CMD_READ_3B)    || (c == `FS_CMD_READ_4B) ||
                    (c == `FS_CMD_FREAD_3B)   || (c == `FS_CMD_FREAD_4B) ||
                    (c == `FS_CMD_DREAD_3B)   || (c == `FS_CMD_DREAD_4B) ||
                    (c == `FS_CMD_DIOREAD_3B) || (c == `FS_CMD_DIOREAD_4B);
  endfunction : is_plain_read

  function automatic logic is_quad_read(input logic [7:0] c);
    is_quad_read = (c == `FS_CMD_QREAD_3B)  || (c == `FS_CMD_QREAD_4B) ||
                   (c == `FS_CMD_QIOREAD_3B) || (c == `FS_CMD_QIOREAD_4B);
  endfunction : is_quad_read

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [1:0] pinSync;
  logic       wpPin;
  logic       holdPin;

  flash_pin_sync #(.WIDTH(2)) uPinSync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .din     ({write_protect_pin_n, holdResetPinN}),
    .dout    (pinSync)
  );

  assign wpPin   = pinSync[1];
  assign holdPin = pinSync[0];

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  state_t          state_q,  state_d;
  logic [BCW-1:0]  busyCnt_q, busyCnt_d;
  logic [RCW-1:0]  rstCnt_q, rstCnt_d;
  logic            armed_q,  armed_d;
  logic            opErase_q, opErase_d;
  sr1_t            sr1_d;
  sr2_t            sr2_d;
  sr3_t            sr3_d;
  logic [7:0]      readData_d;
  logic            readValid_d, cmdReject_d, opStart_d, readGrant_d;
  logic [7:0]      opCode_d;
  logic            suspendReq_d, resumeReq_d;
  logic [3:0]      dummyDual_d, dummyQuad_d;
  drive_t          driveStrength_d;
  logic            quadPins_d, wpActive_d, holdActive_d, pinReset_d;

  logic busy;
  logic srOk;
  logic wpEff;
  logic resetMode;
  logic hwReset;
  logic swReset;
  logic [7:0] code;

  always_comb begin
    state_d     = state_q;
    busyCnt_d   = busyCnt_q;
    armed_d     = armed_q;
    opErase_d   = opErase_q;
    sr1_d       = sr1_q;
    sr2_d       = sr2_q;
    sr3_d       = sr3_q;
    readData_d  = readData_q;
    readValid_d = 1'b0;
    cmdReject_d = 1'b0;
    opStart_d   = 1'b0;
    opCode_d    = opCode_q;
    readGrant_d = 1'b0;
    suspendReq_d = 1'b0;
    resumeReq_d  = 1'b0;
    swReset     = 1'b0;
    code        = cmdIn.code;

    busy  = (state_q == ST_SRW_BUSY) || arrEvt.busy;
    // protect pin counts as high once it serves as a data line
    wpEff = sr2_q.quad_io_enable ? 1'b1 : wpPin;
    case ({sr2_q.lock_mode_bit1, sr1_q.lock_mode_bit0})
      2'b00:   srOk = 1'b1;
      2'b01:   srOk = wpEff;
      default: srOk = 1'b0;
    endcase

    // hardware reset needs the pin low for the full minimum time
    resetMode = !sr2_q.quad_io_enable && sr3_q.pause_or_reset_select;
    if (resetMode && !holdPin) begin
      if (rstCnt_q != RCW'(RST_LOW_CYC))
        rstCnt_d = rstCnt_q + RCW'(1);
      else
        rstCnt_d = rstCnt_q;
    end else begin
      rstCnt_d = '0;
    end
    hwReset = resetMode && !holdPin && (rstCnt_q == RCW'(RST_LOW_CYC - 1));

    if (state_q == ST_SRW_BUSY) begin
      if (busyCnt_q == '0)
        state_d = ST_IDLE;
      else
        busyCnt_d = busyCnt_q - BCW'(1);
    end

    if (cmdIn.valid) begin
      armed_d = (code == `FS_CMD_RESET_ARM);
      case (code)
        `FS_CMD_WRITE_UNLOCK: begin
          if (busy) cmdReject_d = 1'b1;
          else sr1_d.write_enable_latch = 1'b1;
        end
        `FS_CMD_WRITE_LOCK: begin
          if (busy) cmdReject_d = 1'b1;
          else sr1_d.write_enable_latch = 1'b0;
        end
        `FS_CMD_READ_SR1: begin
          readData_d  = sr1_q;
          readValid_d = 1'b1;
        end
        `FS_CMD_READ_SR2: begin
          readData_d  = sr2_q;
          readValid_d = 1'b1;
        end
        `FS_CMD_READ_SR3: begin
          readData_d  = sr3_q;
          readValid_d = 1'b1;
        end
        `FS_CMD_WRITE_SR1, `FS_CMD_WRITE_SR2, `FS_CMD_WRITE_SR3: begin
          if (busy || !sr1_q.write_enable_latch || !srOk) begin
            cmdReject_d = 1'b1;
          end else begin
            if (code == `FS_CMD_WRITE_SR1) begin
              sr1_d.lock_mode_bit0     = cmdIn.data[7];
              sr1_d.protect_range_bits = cmdIn.data[6:2];
            end else if (code == `FS_CMD_WRITE_SR2) begin
              sr2_d.lock_mode_bit1  = cmdIn.data[6];
              // one-time bits: a write can only add ones
              sr2_d.security_lock_3 = sr2_q.security_lock_3 | cmdIn.data[5];
              sr2_d.security_lock_2 = sr2_q.security_lock_2 | cmdIn.data[4];
              sr2_d.security_lock_1 = sr2_q.security_lock_1 | cmdIn.data[3];
              sr2_d.quad_io_enable  = cmdIn.data[1];
            end else begin
              sr3_d.pause_or_reset_select = cmdIn.data[7];
              sr3_d.output_strength_hi    = cmdIn.data[6];
              sr3_d.output_strength_lo    = cmdIn.data[5];
              sr3_d.powerup_addr_width    = cmdIn.data[4];
              sr3_d.latency_sel_hi        = cmdIn.data[1];
              sr3_d.latency_sel_lo        = cmdIn.data[0];
            end
            sr1_d.write_enable_latch = 1'b0;
            state_d   = ST_SRW_BUSY;
            busyCnt_d = BCW'(SRW_BUSY_CYC - 1);
          end
        end
        `FS_CMD_ENTER_4B, `FS_CMD_EXIT_4B: begin
          if (busy) cmdReject_d = 1'b1;
          else sr2_d.current_addr_width_flag = (code == `FS_CMD_ENTER_4B);
        end
        `FS_CMD_SUSPEND: begin
          if (arrEvt.busy) begin
            suspendReq_d = 1'b1;
            if (opErase_q) sr2_d.erase_paused_flag = 1'b1;
            else sr2_d.program_paused_flag = 1'b1;
          end
        end
        `FS_CMD_RESUME: begin
          if (sr2_q.erase_paused_flag || sr2_q.program_paused_flag) begin
            resumeReq_d = 1'b1;
            sr2_d.erase_paused_flag   = 1'b0;
            sr2_d.program_paused_flag = 1'b0;
            if (opErase_q) sr3_d.erase_fail_flag = 1'b0;
            else sr3_d.program_fail_flag = 1'b0;
          end
        end
        `FS_CMD_RESET_ARM: begin
        end
        `FS_CMD_RESET_FIRE: begin
          swReset = armed_q;
        end
        default: begin
          if (is_program(code) || is_erase(code)) begin
            if (busy || !sr1_q.write_enable_latch) begin
              cmdReject_d = 1'b1;
            end else begin
              opStart_d = 1'b1;
              opCode_d  = code;
              opErase_d = is_erase(code);
              sr1_d.write_enable_latch = 1'b0;
              if (is_erase(code)) sr3_d.erase_fail_flag = 1'b0;
              else sr3_d.program_fail_flag = 1'b0;
            end
          end else if (is_plain_read(code) ||
                       (is_quad_read(code) && sr2_q.quad_io_enable)) begin
            if (busy) cmdReject_d = 1'b1;
            else begin
              readGrant_d = 1'b1;
              opCode_d    = code;
            end
          end else begin
            cmdReject_d = 1'b1;
          end
        end
      endcase
    end

    // failure events follow the commands so a set beats a same-cycle command clear, but not a reset
    if (arrEvt.fail || arrEvt.protHit) begin
      if (opErase_q) sr3_d.erase_fail_flag = 1'b1;
      else sr3_d.program_fail_flag = 1'b1;
    end

    if (swReset || hwReset) begin
      state_d   = ST_IDLE;
      busyCnt_d = '0;
      armed_d   = 1'b0;
      sr1_d.write_enable_latch    = 1'b0;
      sr2_d.erase_paused_flag     = 1'b0;
      sr2_d.program_paused_flag   = 1'b0;
      sr3_d.erase_fail_flag       = 1'b0;
      sr3_d.program_fail_flag     = 1'b0;
      sr2_d.current_addr_width_flag = sr3_q.powerup_addr_width;
    end

    sr1_d.write_busy_flag = (state_d == ST_SRW_BUSY) || arrEvt.busy;

    dummyDual_d     = dummy_cycles(sr3_d.latency_sel_lo, 1'b0);
    dummyQuad_d     = dummy_cycles(sr3_d.latency_sel_lo, 1'b1);
    driveStrength_d = drive_t'({sr3_d.output_strength_hi,
                                sr3_d.output_strength_lo});
    quadPins_d   = sr2_d.quad_io_enable;
    wpActive_d   = !sr2_d.quad_io_enable && !wpPin;
    holdActive_d = !sr2_d.quad_io_enable && !sr3_d.pause_or_reset_select &&
                   !holdPin;
    pinReset_d   = hwReset;
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q         <= ST_IDLE;
      busyCnt_q       <= '0;
      rstCnt_q        <= '0;
      armed_q         <= 1'b0;
      opErase_q       <= 1'b0;
      sr1_q           <= `FS_SR1_RST;
      sr2_q           <= `FS_SR2_RST;
      sr3_q           <= `FS_SR3_RST;
      readData_q      <= 8'h00;
      readValid_q     <= 1'b0;
      cmdReject_q     <= 1'b0;
      opStart_q       <= 1'b0;
      opCode_q        <= 8'h00;
      readGrant_q     <= 1'b0;
      suspendReq_q    <= 1'b0;
      resumeReq_q     <= 1'b0;
      dummyDual_q     <= `FS_DUMMY_DUAL_SHORT;
      dummyQuad_q     <= `FS_DUMMY_QUAD_SHORT;
      driveStrength_q <= DRIVE_3Q;
      quadPins_q      <= 1'b0;
      wpActive_q      <= 1'b0;
      holdActive_q    <= 1'b0;
      pinReset_q      <= 1'b0;
    end else if (clkEn) begin
      state_q         <= state_d;
      busyCnt_q       <= busyCnt_d;
      rstCnt_q        <= rstCnt_d;
      armed_q         <= armed_d;
      opErase_q       <= opErase_d;
      sr1_q           <= sr1_d;
      sr2_q           <= sr2_d;
      sr3_q           <= sr3_d;
      readData_q      <= readData_d;
      readValid_q     <= readValid_d;
      cmdReject_q     <= cmdReject_d;
      opStart_q       <= opStart_d;
      opCode_q        <= opCode_d;
      readGrant_q     <= readGrant_d;
      suspendReq_q    <= suspendReq_d;
      resumeReq_q     <= resumeReq_d;
      dummyDual_q     <= dummyDual_d;
      dummyQuad_q     <= dummyQuad_d;
      driveStrength_q <= driveStrength_d;
      quadPins_q      <= quadPins_d;
      wpActive_q      <= wpActive_d;
      holdActive_q    <= holdActive_d;
      pinReset_q      <= pinReset_d;
    end
  end

endmodule : flash_status_register_bank

// ### flash_array_engine_model.sv
// Purpose: array engine that answers program and erase starts
// Assumes: busy runs OP_CYC cycles, pausing while suspended
// Notes:   never reports a failure
`timescale 1ns/100ps
module flash_array_engine_model #(
  parameter int OP_CYC = 20
) (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  opStart,
  input  wire logic                  suspendReq,
  input  wire logic                  resumeReq,
  output flash_status_pkg::arr_evt_t arrEvt
);
  import flash_status_pkg::*;
  int left;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      left   <= 0;
      arrEvt <= '0;
    end else begin
      if (opStart) left <= OP_CYC;
      else if (arrEvt.busy && left > 0) left <= left - 1;
      // suspend freezes the remaining count until resume
      if (opStart || resumeReq) arrEvt.busy <= 1'b1;
      else if (suspendReq || left == 1) arrEvt.busy <= 1'b0;
    end
  end
endmodule : flash_array_engine_model

// ### flash_status_register_bank_monitor.sv
// Purpose: port checker of the status bank
// Assumes: reset is a power cycle
// Notes:   bound to every instance of the bank
`timescale 1ns/100ps
`include "flash_status_cfg.svh"
module flash_status_register_bank_monitor (
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic                 clkEn,
  input flash_status_pkg::cmd_t    cmdIn,
  input flash_status_pkg::arr_evt_t arrEvt,
  input flash_status_pkg::sr1_t    sr1_q,
  input flash_status_pkg::sr2_t    sr2_q,
  input flash_status_pkg::sr3_t    sr3_q,
  input logic                      cmdReject_q,
  input logic                      readGrant_q,
  input logic [3:0]                dummyDual_q,
  input logic [3:0]                dummyQuad_q,
  input flash_status_pkg::drive_t  driveStrength_q
);
  import flash_status_pkg::*;
  logic take;
  logic idle;
  assign take = clkEn && cmdIn.valid;
  assign idle = !sr1_q.write_busy_flag && !arrEvt.busy;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_busy;
    take && cmdIn.code == `FS_CMD_WRITE_SR1 && sr1_q.write_enable_latch
    && idle && !sr1_q.lock_mode_bit0 && !sr2_q.lock_mode_bit1
    |=> sr1_q.write_busy_flag;
  endproperty
  a_busy: assert property (p_busy)
    else $error("status write did not raise busy");
  property p_wel;
    take && cmdIn.code == `FS_CMD_WRITE_UNLOCK && idle
    |=> sr1_q.write_enable_latch;
  endproperty
  a_wel: assert property (p_wel)
    else $error("unlock did not set latch");
  property p_nowel;
    take && !sr1_q.write_enable_latch && cmdIn.code inside
    {`FS_CMD_WRITE_SR1, `FS_CMD_WRITE_SR2, `FS_CMD_PROG_3B}
    |=> cmdReject_q && $stable(sr1_q.protect_range_bits);
  endproperty
  a_nowel: assert property (p_nowel)
    else $error("write accepted with latch clear");
  property p_ads;
    take && cmdIn.code == `FS_CMD_WRITE_SR2
    |=> $stable(sr2_q.current_addr_width_flag);
  endproperty
  a_ads: assert property (p_ads)
    else $error("address width flag written");
  property p_otp;
    sr2_q.security_lock_1 |=> sr2_q.security_lock_1;
  endproperty
  a_otp: assert property (p_otp)
    else $error("security lock cleared");
  property p_resume;
    take && cmdIn.code == `FS_CMD_RESUME
    |=> !sr2_q.program_paused_flag && !sr2_q.erase_paused_flag;
  endproperty
  a_resume: assert property (p_resume)
    else $error("paused flag kept after resume");
  property p_quad;
    take && cmdIn.code == `FS_CMD_QIOREAD_3B && !sr2_q.quad_io_enable
    |=> cmdReject_q && !readGrant_q;
  endproperty
  a_quad: assert property (p_quad)
    else $error("quad read run without quad enable");
  property p_cfg;
    $stable(sr3_q)[*2] |-> dummyDual_q == (sr3_q.latency_sel_lo ? 4'h8 : 4'h4)
    && dummyQuad_q == (sr3_q.latency_sel_lo ? 4'hA : 4'h6) && driveStrength_q
    == drive_t'({sr3_q.output_strength_hi, sr3_q.output_strength_lo});
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("dummy count or drive mismatch");
endmodule : flash_status_register_bank_monitor
bind flash_status_register_bank flash_status_register_bank_monitor u_mon (
  .ref_clk, .resetn, .clkEn, .cmdIn, .arrEvt, .sr1_q, .sr2_q, .sr3_q,
  .cmdReject_q, .readGrant_q, .dummyDual_q, .dummyQuad_q, .driveStrength_q);

// ### tb_flash_status_register_bank.sv
// Purpose: self-checking bench of the status bank
// Assumes: clkEn and the shared pin held high
// Notes:   status-write busy shortened to 2 cycles
`timescale 1ns/100ps
`include "flash_status_cfg.svh"
module tb_flash_status_register_bank;
  import flash_status_pkg::*;
  logic       ref_clk, resetn, wpN, rv, rej, ops, rg, sus, res, wpa, qp;
  cmd_t       cmdIn;
  arr_evt_t   arrEvt;
  sr1_t       sr1;
  sr2_t       sr2;
  sr3_t       sr3;
  logic [7:0] rdat, opc;
  logic [3:0] dd, dq;
  drive_t     drv;
  int         mismatches, n_tests, cyc;
  flash_status_register_bank #(.SRW_BUSY_CYC(2), .RST_LOW_CYC(3))
    flash_status_register_bank_inst (.ref_clk, .resetn, .clkEn(1'b1),
    .cmdIn, .arrEvt, .write_protect_pin_n(wpN), .holdResetPinN(1'b1),
    .sr1_q(sr1), .sr2_q(sr2), .sr3_q(sr3), .readData_q(rdat),
    .readValid_q(rv), .cmdReject_q(rej), .opStart_q(ops), .opCode_q(opc),
    .readGrant_q(rg), .suspendReq_q(sus), .resumeReq_q(res),
    .dummyDual_q(dd), .dummyQuad_q(dq), .driveStrength_q(drv),
    .quadPins_q(qp), .wpActive_q(wpa), .holdActive_q(), .pinReset_q());
  flash_array_engine_model flash_array_engine_model_inst (.ref_clk,
    .resetn, .opStart(ops), .suspendReq(sus), .resumeReq(res), .arrEvt);
  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-beat command; returns just after the taking edge
  task automatic cmd(input logic [7:0] c, input logic [7:0] d = 8'h00);
    @(posedge ref_clk);
    cmdIn <= '{1'b1, c, d};
    @(posedge ref_clk);
    cmdIn.valid <= 1'b0;
    #1;
  endtask : cmd
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd(`FS_CMD_WRITE_UNLOCK);
    cmd(c, d);
    for (int i = 0; i < 40 && sr1.write_busy_flag !== 1'b0; i++)
      @(posedge ref_clk) #1;
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    cmd(c);
    chk({7'h0, rv}, 8'h01);
    chk(rdat, e);
  endtask : rd
  task automatic t_wel;
    cmd(`FS_CMD_WRITE_SR1, 8'h1C);
    chk({7'h0, rej}, 8'h01);
    rd(`FS_CMD_READ_SR1, 8'h00);
    cmd(`FS_CMD_WRITE_UNLOCK);
    chk(sr1, 8'h02);
    cmd(`FS_CMD_WRITE_SR1, 8'h1C);
    chk(sr1, 8'h1D);
    wr(`FS_CMD_READ_SR1, 8'h00);
    rd(`FS_CMD_READ_SR1, 8'h1C);
  endtask : t_wel
  task automatic t_lock;
    wr(`FS_CMD_WRITE_SR1, 8'h80);
    @(posedge ref_clk) wpN <= 1'b0;
    wr(`FS_CMD_WRITE_SR1, 8'h00);
    chk({5'h00, wpa, rej, sr1.lock_mode_bit0}, 8'h07);
    @(posedge ref_clk) wpN <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(`FS_CMD_WRITE_SR1, 8'h00);
    chk({7'h0, sr1.lock_mode_bit0}, 8'h00);
    wr(`FS_CMD_WRITE_SR2, 8'h40);
    wr(`FS_CMD_WRITE_SR2, 8'h00);
    chk({6'h00, rej, sr2.lock_mode_bit1}, 8'h03);
    @(posedge ref_clk) resetn <= 1'b0;
    @(posedge ref_clk) resetn <= 1'b1;
    rd(`FS_CMD_READ_SR2, `FS_SR2_RST);
  endtask : t_lock
  task automatic t_misc;
    wr(`FS_CMD_WRITE_SR2, 8'h09);
    rd(`FS_CMD_READ_SR2, 8'h08);
    cmd(`FS_CMD_QIOREAD_3B);
    chk({6'h00, rej, rg}, 8'h02);
    wr(`FS_CMD_WRITE_SR2, 8'h02);
    rd(`FS_CMD_READ_SR2, 8'h0A);
    cmd(`FS_CMD_QIOREAD_3B);
    chk({5'h00, qp, rej, rg}, 8'h05);
    wr(`FS_CMD_PROG_3B, 8'h00);
    chk({6'h00, sr1.write_enable_latch, ops}, 8'h01);
    cmd(`FS_CMD_SUSPEND);
    chk({5'h00, sr1[0], sr2[2], sr2[7]}, 8'h06);
    cmd(`FS_CMD_RESUME);
    chk({6'h00, sr2.program_paused_flag, res}, 8'h01);
    wr(`FS_CMD_READ_SR1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`FS_CMD_WRITE_SR3, {1'b0, i[1:0], 3'b000, i[1:0]});
      chk({dd, dq}, i[0] ? 8'h8A : 8'h46);
      chk({6'h00, drv}, i[7:0]);
    end
  endtask : t_misc
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      $display("[ERR] %0t run too long", $time);
      stop_test();
    end
  end
  initial begin
    resetn = 1'b0;
    wpN = 1'b1;
    cmdIn = '0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`FS_CMD_READ_SR1, `FS_SR1_RST);
    rd(`FS_CMD_READ_SR3, `FS_SR3_RST);
    chk({dd, dq}, 8'h46);
    t_wel();
    t_lock();
    t_misc();
    stop_test();
  end
endmodule : tb_flash_status_register_bank
